/* qsb_sram_burst.sv */
// two-beat burst sram core with lane-masked writes, seen from the pins
//
// Summary of operation
// [R1] x9: mask low writes bits 0-8
// [R2] x18: mask0 gates 0-8, mask1 gates 9-17
// [R3] x36: four masks gate four 9-bit lanes
// [R4] masks sampled separately on each write beat
// [R5] address extended by internal beat bit
// [R6] beat order fixed: base+0 then base+1
// [R7] every burst ends after exactly two beats
// [R8] read and write sequencers run concurrently
// [R9] write sequencer advances only on input clock rises; read beats move on output clock rises
// [R10] write: select low at clock rise, two beats
// [R11] read word0 at C# t+1, word1 at C t+2
// [R12] both output clocks high: use input clocks
// [R13] selects registered only on input clock rise
// [R14] masked lanes keep their stored contents
`timescale 1ns/1ps
`include "qsb_defines.svh"

module qsb_sram_burst #(
	parameter logic [1:0] ORG = `QSB_ORG_X36
) (
	input  wire logic                    clk_sys_in,
	input  wire logic                    rst_n_in,
	input  wire logic                    in_clk_in,
	input  wire logic                    in_clk_n_in,
	input  wire logic                    out_clk_in,
	input  wire logic                    out_clk_n_in,
	input  wire logic                    rd_sel_n_in,
	input  wire logic                    wr_sel_n_in,
	input  wire logic [`QSB_ADDR_W-1:0]  addr_in,
	input  wire logic [`QSB_DATA_W-1:0]  data_in,
	input  wire logic                    lane_write_mask_0_in,
	input  wire logic                    lane_write_mask_1_in,
	input  wire logic                    lane_write_mask_2_in,
	input  wire logic                    lane_write_mask_3_in,
	output logic      [`QSB_DATA_W-1:0]  q_out,
	output logic                         q_oe_out
);

	// number of lanes the chosen organisation really has
	localparam logic [2:0] LANES_USED =
		(ORG == `QSB_ORG_X9)  ? `QSB_LANES_X9  :
		(ORG == `QSB_ORG_X18) ? `QSB_LANES_X18 : `QSB_LANES_X36;

	localparam int IDX_W = `QSB_ADDR_W + 1;

	qsb_pkg::qsb_state_s                 st_reg;
	qsb_pkg::qsb_state_s                 st_next;
	qsb_pkg::qsb_pins_s                  pins;
	qsb_pkg::qsb_pins_s                  smp;
	logic                                k_rise;
	logic                                k_n_rise;
	logic                                oc_rise;
	logic                                oc_n_rise;
	logic                                wr_en;
	logic [IDX_W-1:0]                    wr_idx;
	logic [IDX_W-1:0]                    rd_idx;
	logic [`QSB_DATA_W-1:0]              rd_word;
	logic [`QSB_LANES-1:0]               lane_we;

	// all pins travel as one bundle so beats stay aligned after syncing
	always_comb begin
		pins.k        = in_clk_in;
		pins.k_n      = in_clk_n_in;
		pins.c        = out_clk_in;
		pins.c_n      = out_clk_n_in;
		pins.rd_sel_n = rd_sel_n_in;
		pins.wr_sel_n = wr_sel_n_in;
		pins.addr     = addr_in;
		pins.data     = data_in;
		pins.mask     = {lane_write_mask_3_in, lane_write_mask_2_in,
			lane_write_mask_1_in, lane_write_mask_0_in};
	end

	// edges found on the second sync stage only
	always_comb begin
		smp       = st_reg.sync2;
		k_rise    = smp.k & ~st_reg.k_prev;
		k_n_rise  = smp.k_n & ~st_reg.k_n_prev;
		// both output clocks parked high: deliver on input clocks
		if (smp.c && smp.c_n) begin  // [R12]
			oc_rise   = k_rise;
			oc_n_rise = k_n_rise;
		end else begin
			oc_rise   = smp.c & ~st_reg.c_prev;
			oc_n_rise = smp.c_n & ~st_reg.c_n_prev;
		end
	end

	// lane enables for the beat being written; unused lanes never write
	generate
		for (genvar i = 0; i < `QSB_LANES; i++) begin : g_lane_en
			assign lane_we[i] = wr_en && (i < LANES_USED)
				&& !smp.mask[i];  // [R1] [R2] [R3] [R4]
		end
	endgenerate

	// next-state logic for both sequencers
	always_comb begin
		st_next          = st_reg;
		st_next.sync1    = pins;
		st_next.sync2    = st_reg.sync1;
		st_next.k_prev   = smp.k;
		st_next.k_n_prev = smp.k_n;
		st_next.c_prev   = smp.c;
		st_next.c_n_prev = smp.c_n;
		wr_en            = 1'b0;
		wr_idx           = {st_reg.wr_addr, `QSB_BEAT0};

		// write sequencer: state moves only on input clock and input clock-bar rises
		case (st_reg.wr_state)
		qsb_pkg::QSB_WR_IDLE: begin
			if (k_rise && !smp.wr_sel_n) begin  // [R9] [R10] [R13]
				st_next.wr_addr  = smp.addr;
				st_next.wr_state = qsb_pkg::QSB_WR_BEAT1;
				wr_en            = 1'b1;
				wr_idx           = {smp.addr, `QSB_BEAT0};  // [R5] [R6]
			end
		end
		qsb_pkg::QSB_WR_BEAT1: begin
			// second beat on the complementary clock, then done
			if (k_n_rise) begin  // [R10]
				wr_en            = 1'b1;
				wr_idx           = {st_reg.wr_addr, `QSB_BEAT1};  // [R6]
				st_next.wr_state = qsb_pkg::QSB_WR_IDLE;  // [R7]
			end
		end
		default: begin
			st_next.wr_state = qsb_pkg::QSB_WR_IDLE;
		end
		endcase

		// read sequencer, independent of the write side
		rd_idx = {st_reg.rd_arm_addr, `QSB_BEAT0};
		if (oc_n_rise) begin
			rd_idx = {st_reg.rd_arm_addr, `QSB_BEAT0};  // [R5] [R6]
		end else if (oc_rise) begin
			rd_idx = {st_reg.rd_b1_addr, `QSB_BEAT1};  // [R6]
		end
		// output-clock rise: beat 1 or float, and arm the pending read
		if (oc_rise) begin
			st_next.q_oe     = st_reg.rd_b1_v;  // [R11]
			st_next.q        = st_reg.rd_b1_v ? rd_word : st_reg.q;
			st_next.rd_b1_v  = 1'b0;  // [R7]
			st_next.rd_arm_v = st_reg.rd_pend_v;
			st_next.rd_arm_addr = st_reg.rd_pend_addr;
			st_next.rd_pend_v = 1'b0;
		end
		// output-clock-bar rise of the next cycle: beat 0
		if (oc_n_rise && st_reg.rd_arm_v) begin
			st_next.q          = rd_word;  // [R11]
			st_next.q_oe       = 1'b1;
			st_next.rd_b1_v    = 1'b1;
			st_next.rd_b1_addr = st_reg.rd_arm_addr;
			st_next.rd_arm_v   = 1'b0;
		end
		// a new read is loaded only on input clock rise [R8] [R13]
		if (k_rise && !smp.rd_sel_n) begin  // [R9] [R11]
			st_next.rd_pend_v    = 1'b1;
			st_next.rd_pend_addr = smp.addr;
		end
	end

	// storage: one array per lane so masked lanes are simply left alone
	generate
		for (genvar i = 0; i < `QSB_LANES; i++) begin : g_lane_mem
			logic [`QSB_LANE_W-1:0] mem [0:`QSB_WORDS-1];
			always_ff @(posedge clk_sys_in) begin
				if (lane_we[i]) begin  // [R14]
					mem[wr_idx] <= smp.data[i*`QSB_LANE_W +:
						`QSB_LANE_W];
				end
			end
			// read of a lane outside the organisation shows zero
			assign rd_word[i*`QSB_LANE_W +: `QSB_LANE_W] =
				(i < LANES_USED) ? mem[rd_idx] : '0;
		end
	endgenerate

	// state register; memory contents are not reset
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg          <= '0;
			st_reg.wr_state <= qsb_pkg::QSB_WR_IDLE;
			st_reg.sync1.rd_sel_n <= 1'b1;
			st_reg.sync1.wr_sel_n <= 1'b1;
			st_reg.sync2.rd_sel_n <= 1'b1;
			st_reg.sync2.wr_sel_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q_out    = st_reg.q;
	assign q_oe_out = st_reg.q_oe;

endmodule

/* qsb_defines.svh */
// constants for the burst sram write-lane and sequencer block
`ifndef QSB_DEFINES_SVH
`define QSB_DEFINES_SVH

`define QSB_ADDR_W     4
`define QSB_LANE_W     9
`define QSB_LANES      4
`define QSB_DATA_W     36
`define QSB_WORDS      32
`define QSB_BEAT0      1'b0
`define QSB_BEAT1      1'b1
`define QSB_ORG_X9     2'h0
`define QSB_ORG_X18    2'h1
`define QSB_ORG_X36    2'h2
`define QSB_LANES_X9   3'h1
`define QSB_LANES_X18  3'h2
`define QSB_LANES_X36  3'h4

`endif

/* qsb_pkg.sv */
// types for the burst sram write-lane and sequencer block
`include "qsb_defines.svh"
package qsb_pkg;

	typedef enum logic [1:0] {
		QSB_WR_IDLE  = 2'h0,
		QSB_WR_BEAT1 = 2'h1
	} qsb_wr_state_e;

	// one sample of every pin, synchronised as a group
	typedef struct packed {
		logic                    k;
		logic                    k_n;
		logic                    c;
		logic                    c_n;
		logic                    rd_sel_n;
		logic                    wr_sel_n;
		logic [`QSB_ADDR_W-1:0]  addr;
		logic [`QSB_DATA_W-1:0]  data;
		logic [`QSB_LANES-1:0]   mask;
	} qsb_pins_s;

	typedef struct packed {
		qsb_pins_s               sync1;
		qsb_pins_s               sync2;
		logic                    k_prev;
		logic                    k_n_prev;
		logic                    c_prev;
		logic                    c_n_prev;
		qsb_wr_state_e           wr_state;
		logic [`QSB_ADDR_W-1:0]  wr_addr;
		logic                    rd_pend_v;
		logic [`QSB_ADDR_W-1:0]  rd_pend_addr;
		logic                    rd_arm_v;
		logic [`QSB_ADDR_W-1:0]  rd_arm_addr;
		logic                    rd_b1_v;
		logic [`QSB_ADDR_W-1:0]  rd_b1_addr;
		logic [`QSB_DATA_W-1:0]  q;
		logic                    q_oe;
	} qsb_state_s;

endpackage

/* qsb_ctl_model.sv */
// controller model: link clocks and request pins of the sram
`timescale 1ns/1ps
module qsb_ctl_model (
	input  wire logic   clk_in,
	input  wire logic   fb_in,
	output logic        k_out,
	output logic        kn_out,
	output logic        c_out,
	output logic        cn_out,
	output logic        rd_n_out,
	output logic        wr_n_out,
	output logic [3:0]  a_out,
	output logic [35:0] d_out,
	output logic [3:0]  m_out
);
	// free-running link clock, phase unrelated to clk_in
	initial begin
		k_out = 1'b0;
		#7;
		forever #80 k_out = ~k_out;
	end
	// both output clocks held high hand read timing to k
	assign kn_out = ~k_out;
	assign c_out = k_out | fb_in;
	assign cn_out = kn_out | fb_in;
	initial {rd_n_out, wr_n_out, a_out, d_out, m_out} = {2'h3, 44'h0};
	// one k cycle; pins move 2 clk after an edge so hold is kept
	task automatic cyc(input logic r, w, input logic [3:0] a, m0, m1,
		input logic [35:0] d0, d1);
		@(posedge kn_out);
		repeat (2) @(posedge clk_in);
		{rd_n_out, wr_n_out, a_out} <= {~r, ~w, a};
		{d_out, m_out} <= {d0, m0};
		@(posedge k_out);
		repeat (2) @(posedge clk_in);
		{rd_n_out, wr_n_out} <= 2'h3;
		{d_out, m_out} <= {d1, m1};
		@(posedge kn_out);
		repeat (2) @(posedge clk_in);
		// hold expired: never leave the last beat showing
		{a_out, d_out, m_out} <= ~{a, d1, m1};
	endtask
endmodule

/* qsb_sram_burst_sva.sv */
// port checks for the burst sram block
`timescale 1ns/1ps
module qsb_sram_burst_sva (
	input wire logic        clk_sys_in,
	input wire logic        rst_n_in,
	input wire logic        in_clk_in,
	input wire logic        in_clk_n_in,
	input wire logic        out_clk_in,
	input wire logic        out_clk_n_in,
	input wire logic        rd_sel_n_in,
	input wire logic [35:0] q_out,
	input wire logic        q_oe_out
);
	logic [14:0] sh_reg;
	logic [4:0]  age_reg;
	wire  [4:0]  s2 = sh_reg[9:5];
	wire  [4:0]  r = s2 & ~sh_reg[14:10];
	wire         fb = s2[2] & s2[1];
	wire  [1:0]  er = fb ? r[4:3] : r[2:1];
	// retimed like the block so edges line up; age since last read
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
		if (!rst_n_in)
			{sh_reg, age_reg} <= {15'h0421, 5'h1f};
		else begin
			sh_reg <= {sh_reg[9:0], in_clk_in, in_clk_n_in, out_clk_in,
				out_clk_n_in, rd_sel_n_in};
			age_reg <= (r[4] && !s2[0]) ? 5'h0
				: age_reg + {4'h0, age_reg != 5'h1f};
		end
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);
	a_reset_quiet: assert property ($rose(rst_n_in) |-> !q_oe_out)
		else $error("output enabled after reset");
	a_q_on_edge: assert property ($changed(q_out) |-> $past(|er))
		else $error("read data moved without output clock edge");
	a_q_driven: assert property ($changed(q_out) |-> q_oe_out)
		else $error("read data moved while floating");
	a_oe_on_cn: assert property ($rose(q_oe_out) |-> $past(er[0]))
		else $error("first word not on complement clock");
	a_oe_off_c: assert property ($fell(q_oe_out) |-> $past(er[1]))
		else $error("bus release not on output clock");
	a_oe_burst: assert property ($rose(q_oe_out) |-> q_oe_out [*8])
		else $error("burst shorter than two words");
	a_read_lag: assert property ($rose(q_oe_out) |->
		age_reg inside {5'd4, 5'd12}) else $error("read latency wrong");
	a_fallback: assert property ($changed(q_out) && $past(fb) |->
		$past(r[4] | r[3])) else $error("fallback not on input clock");
	cover property ($rose(q_oe_out));
	cover property ($fell(q_oe_out));
	cover property (fb && $changed(q_out));
endmodule
bind qsb_sram_burst qsb_sram_burst_sva u_sva (.*);

/* testbench.sv */
// self-checking bench for the burst sram block
`timescale 1ns/1ps
`include "qsb_defines.svh"
module testbench;
	logic        clk_sys_in, rst_n_in, fb, q_oe_out;
	logic [35:0] q_out;
	logic [35:0] mem [16][2];
	wire         in_clk_in, in_clk_n_in, out_clk_in, out_clk_n_in;
	wire         rd_sel_n_in, wr_sel_n_in;
	wire  [3:0]  addr_in;
	wire  [35:0] data_in;
	wire         lane_write_mask_0_in, lane_write_mask_1_in;
	wire         lane_write_mask_2_in, lane_write_mask_3_in;
	int          failures, compares;
	logic        q_oe_x9, q_oe_x18;
	logic [35:0] q_x9, q_x18;
	qsb_sram_burst dut (.*);
	// narrow organisations share the pins; unused lanes must read zero
	qsb_sram_burst #(.ORG(`QSB_ORG_X9)) dut_x9 (.*, .q_out(q_x9),
		.q_oe_out(q_oe_x9));
	qsb_sram_burst #(.ORG(`QSB_ORG_X18)) dut_x18 (.*, .q_out(q_x18),
		.q_oe_out(q_oe_x18));
	qsb_ctl_model u_ctl (.clk_in(clk_sys_in), .fb_in(fb), .k_out(in_clk_in),
		.kn_out(in_clk_n_in), .c_out(out_clk_in), .cn_out(out_clk_n_in),
		.rd_n_out(rd_sel_n_in), .wr_n_out(wr_sel_n_in), .a_out(addr_in),
		.d_out(data_in), .m_out({lane_write_mask_3_in, lane_write_mask_2_in,
		lane_write_mask_1_in, lane_write_mask_0_in}));
	task automatic chk(input logic [35:0] got, exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask
	// lanes with a low mask take new data, others keep the old word
	function automatic logic [35:0] merge(input logic [35:0] o, n,
		input logic [3:0] m);
		for (int i = 0; i < 4; i++)
			if (!m[i]) o[9*i +: 9] = n[9*i +: 9];
		return o;
	endfunction
	// one k cycle of requests; write lands before a paired read
	task automatic op(input logic r, w, input logic [3:0] a, m0, m1);
		logic [35:0] d0, d1;
		d0 = {4'($urandom), $urandom};
		d1 = {4'($urandom), $urandom};
		u_ctl.cyc(r, w, a, m0, m1, d0, d1);
		if (w) begin
			mem[a][0] = merge(mem[a][0], d0, m0);
			mem[a][1] = merge(mem[a][1], d1, m1);
		end
		if (r) begin
			@(posedge in_clk_in);
			@(posedge in_clk_n_in);
			repeat (5) @(negedge clk_sys_in);
			chk(36'(q_oe_out), 36'h1);
			chk(36'({q_oe_x9, q_oe_x18}), 36'h3);
			chk(q_out, mem[a][0]);
			chk(q_x9, mem[a][0] & 36'h0000001ff);
			chk(q_x18, mem[a][0] & 36'h00003ffff);
			@(posedge in_clk_in);
			repeat (5) @(negedge clk_sys_in);
			chk(q_out, mem[a][1]);
			chk(q_x9, mem[a][1] & 36'h0000001ff);
			chk(q_x18, mem[a][1] & 36'h00003ffff);
			@(posedge in_clk_in);
			repeat (5) @(negedge clk_sys_in);
			chk(36'(q_oe_out), 36'h0);
			chk(36'({q_oe_x9, q_oe_x18}), 36'h0);
		end
	endtask
	task automatic report_and_stop();
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		clk_sys_in = 1'b0;
		forever #10 clk_sys_in = ~clk_sys_in;
	end
	// cut a hang short well after the expected run time
	initial begin
		#200000;
		failures++;
		report_and_stop();
	end
	initial begin
		{rst_n_in, fb, failures, compares} = '0;
		void'($urandom(21));
		repeat (20) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		// fill every word so reads have a defined reference
		for (int i = 0; i < 16; i++)
			op(1'b0, 1'b1, 4'(i), 4'h0, 4'h0);
		// each single lane and none, single-lane masks differ per beat
		for (int i = 0; i < 5; i++)
			op(1'b1, 1'b1, 4'h9, ~(4'h1 << i), ~(4'h8 >> i));
		// random mix, last part with output clocks parked high
		for (int i = 0; i < 48; i++) begin
			@(posedge clk_sys_in);
			fb <= (i >= 32);
			op(1'($urandom), 1'($urandom), 4'($urandom), 4'($urandom),
				4'($urandom));
		end
		report_and_stop();
	end
endmodule
